/* File: core/flash_prot_pkg.sv */
package flash_prot_pkg;

    // ====
    // Register port offsets.
    // ====
    localparam logic [7:0] REG_STATUS_ONE   = 8'h00;  // Range protection fields.
    localparam logic [7:0] REG_STATUS_TWO   = 8'h01;  // Complement, locks, quad enable.
    localparam logic [7:0] REG_STATUS_THREE = 8'h02;  // Pin function, drive, scheme.
    localparam logic [7:0] REG_MODE         = 8'h03;  // Four-wire command mode flag.
    localparam logic [7:0] REG_LOCK_SELECT  = 8'h04;  // Index of one individual lock.
    localparam logic [7:0] REG_LOCK_DATA    = 8'h05;  // Value of the selected lock.

    // ====
    // Field positions inside the status bytes.
    // ====
    localparam int BIT_SECTOR  = 6;  // Sector granularity in status byte one.
    localparam int BIT_TOPBOT  = 5;  // Top-bottom select in status byte one.
    localparam int BIT_BP_LO   = 2;  // Lowest range code bit in status byte one.
    localparam int BIT_COMPL   = 6;  // Complement in status byte two.
    localparam int BIT_LOCK_LO = 3;  // Lowest security lock bit in status byte two.
    localparam int BIT_QUAD    = 1;  // Quad enable in status byte two.
    localparam int BIT_PINF    = 7;  // Pin function select in status byte three.
    localparam int BIT_DRV_LO  = 5;  // Lowest drive bit in status byte three.
    localparam int BIT_SCHEME  = 2;  // Scheme select in status byte three.

    // ====
    // Reset values and commands.
    // ====
    localparam logic [1:0] DRV_RESET   = 2'b11;  // Weakest drive after reset.
    localparam logic [7:0] CMD_ENTER_4W = 8'h38; // Enter four-wire command mode.
    localparam logic [7:0] CMD_EXIT_4W  = 8'hff; // Leave four-wire command mode.

    // ====
    // Array geometry.
    // ====
    localparam int         NUM_LOCKS   = 94;         // 16 + 62 + 16 lock bits.
    localparam logic [6:0] LOCK_MID    = 7'd16;      // First block lock index.
    localparam logic [6:0] LOCK_TOP    = 7'd78;      // First top sector lock index.
    localparam logic [21:0] ARRAY_LAST = 22'h3fffff; // Last byte of the array.
    localparam logic [21:0] SIZE_PAGE  = 22'h000100; // Page and security area size.
    localparam logic [21:0] SIZE_4K    = 22'h001000; // Sector size.
    localparam logic [21:0] SIZE_32K   = 22'h008000; // Half block size.
    localparam logic [21:0] SIZE_64K   = 22'h010000; // Block size.

    // Kinds of program or erase operations offered for checking.
    typedef enum logic [2:0] {
        OP_PAGE     = 3'b000,  // Page program, 256 bytes.
        OP_SECTOR   = 3'b001,  // 4KB sector erase.
        OP_HALF     = 3'b010,  // 32KB block erase.
        OP_BLOCK    = 3'b011,  // 64KB block erase.
        OP_CHIP     = 3'b100,  // Whole array erase.
        OP_AREA     = 3'b101   // Security area program or erase.
    } op_kind_t;

endpackage

/* File: core/flash_status_config_protect.sv */
// Local design decisions: the address map and strobed register access.
`timescale 1ns/10ps
// Function
// RULE1: three OTP security lock bits, default unlocked
// RULE2: set lock stays set, area read-only
// RULE3: quad enable swaps pin functions for data
// RULE4: enter four-wire mode needs quad enable
// RULE5: four-wire mode keeps quad enable at one; a status byte two write in the cycle that enters the mode still clears it
// RULE6: scheme select picks range or individual locks
// RULE7: individual locks all set after reset
// RULE8: two-bit drive field, default weakest
// RULE9: shared pin is hold or reset input
// RULE10: quad enable disables hold and reset
// RULE11: reserved bits ignored on write, read zero
// RULE12: code 000 protects none, 111 all
// RULE13: block spans grow by powers of two
// RULE14: sector spans 4KB to 32KB at ends
// RULE15: reject operations touching protected memory
// RULE16: status byte three bit order fixed
module flash_status_config_protect (
    input  wire logic                      ref_clk,         // 10 MHz clock.
    input  wire logic                      resetn,          // Async reset, low.
    input  wire logic [7:0]                reg_addr,        // Register offset.
    input  wire logic [7:0]                reg_wdata,       // Write data.
    input  wire logic                      reg_wr,          // Write strobe.
    input  wire logic                      reg_rd,          // Read strobe.
    output logic      [7:0]                reg_rdata,       // Read data, next cycle.
    input  wire logic                      cmd_valid,       // Command byte strobe.
    input  wire logic [7:0]                cmd_code,        // Command byte.
    input  wire logic                      chk_valid,       // Check request strobe.
    input  wire flash_prot_pkg::op_kind_t  chk_kind,        // Operation kind.
    input  wire logic [21:0]               chk_addr,        // Target byte address.
    output logic                           chk_done,        // Check answer pulse.
    output logic                           chk_allow,       // One when allowed.
    input  wire logic                      shared_pin_n,    // Hold or reset pin.
    output logic                           four_wire_mode,  // Four-wire mode flag.
    output logic                           quad_data_lines, // Data lines 2 and 3 on.
    output logic                           wp_function_on,  // Write-protect pin live.
    output logic                           hold_active,     // Hold asserted.
    output logic                           pin_reset_req,   // Reset asserted by pin.
    output logic      [1:0]                drive_strength   // Output drive code.
);

    // ====
    // State.
    // ====
    typedef struct packed {
        logic [2:0]  range_code;       // Range code bits 2 to 0.
        logic        top_bottom;       // Zero protects the top end.
        logic        sector_gran;      // One selects sector granularity.
        logic        complement;       // Complement bit.
        logic [2:0]  area_locks;       // Security area locks 3 to 1.
        logic        quad_enable;      // Quad enable bit.
        logic        scheme_sel;       // One selects individual locks.
        logic [1:0]  drive;            // Drive field.
        logic        pin_func;         // One makes the shared pin a reset.
        logic        four_wire;        // Four-wire command mode.
        logic [93:0] locks;            // Individual sector and block locks.
        logic [6:0]  lock_sel;         // Selected lock index.
        logic [7:0]  rdata;            // Registered read data.
        logic        done;             // Check answer pulse.
        logic        allow;            // Check answer value.
        logic        pin_meta;         // First synchroniser stage.
        logic        pin_sync;         // Second synchroniser stage.
        logic        hold;             // Registered hold state.
        logic        prst;             // Registered pin reset state.
        logic        quad_io;          // Registered pin mode.
        logic        wp_on;            // Registered write-protect enable.
    } state_t;

    state_t cur;   // Present state.
    state_t next_; // Next state.

    // ====
    // Helper functions.
    // ====
    // Span of the range protection for codes 001 to 110.
    function automatic logic [21:0] span(input logic [2:0] code, input logic by_sector);
        logic [21:0] s;
        s = flash_prot_pkg::SIZE_64K << (code - 3'd1);  // see RULE13
        if (by_sector) begin
            case (code)  // see RULE14
                3'b001:  s = flash_prot_pkg::SIZE_4K;
                3'b010:  s = flash_prot_pkg::SIZE_4K << 1;
                3'b011:  s = flash_prot_pkg::SIZE_4K << 2;
                default: s = flash_prot_pkg::SIZE_32K;
            endcase
        end
        return s;
    endfunction

    // Size of the region that an operation touches.
    function automatic logic [21:0] op_size(input flash_prot_pkg::op_kind_t k);
        logic [21:0] s;
        case (k)
            flash_prot_pkg::OP_SECTOR: s = flash_prot_pkg::SIZE_4K;
            flash_prot_pkg::OP_HALF:   s = flash_prot_pkg::SIZE_32K;
            flash_prot_pkg::OP_BLOCK:  s = flash_prot_pkg::SIZE_64K;
            default:                   s = flash_prot_pkg::SIZE_PAGE;
        endcase
        return s;
    endfunction

    // ====
    // Protection decode.
    // ====
    logic [21:0] reg_first;  // First byte of the operation.
    logic [21:0] reg_last;   // Last byte of the operation.
    logic [21:0] prot_span;  // Size of the protected span.
    logic [21:0] prot_lo;    // First protected byte.
    logic [21:0] prot_hi;    // Last protected byte.
    logic        range_hit;  // Range scheme protects part of the region.
    logic        lock_hit;   // Individual scheme protects part of the region.
    logic [1:0]  area_idx;   // Security area number.
    logic        verdict;    // Allowed when one.

    // Works out whether the requested region touches protected memory.
    always_comb begin
        int i;
        i = 0;
        reg_first = chk_addr & ~(op_size(chk_kind) - 22'd1);
        reg_last  = reg_first | (op_size(chk_kind) - 22'd1);
        if (chk_kind == flash_prot_pkg::OP_CHIP) begin
            reg_first = 22'h000000;
            reg_last  = flash_prot_pkg::ARRAY_LAST;
        end
        prot_span = span(cur.range_code, cur.sector_gran);
        // Top end when top-bottom is zero, bottom end otherwise.
        prot_lo = cur.top_bottom ? 22'h000000 : ~(prot_span - 22'd1);  // see RULE13
        prot_hi = cur.top_bottom ? (prot_span - 22'd1) : flash_prot_pkg::ARRAY_LAST;
        if (cur.range_code == 3'b000) begin
            range_hit = 1'b0;  // see RULE12
        end else if (cur.range_code == 3'b111) begin
            range_hit = 1'b1;  // see RULE12
        end else begin
            range_hit = !(reg_last < prot_lo || reg_first > prot_hi);
        end
        // The complemented table is not decoded; it is treated as all protected.
        if (cur.complement) begin
            range_hit = 1'b1;
        end
        // Individual locks: end blocks by sector, the rest by block.
        lock_hit = 1'b0;
        if (chk_kind == flash_prot_pkg::OP_CHIP) begin
            lock_hit = |cur.locks;
        end else if (reg_first[21:16] == 6'd0 || reg_first[21:16] == 6'd63) begin
            for (i = 0; i < 16; i++) begin
                if (i >= int'(reg_first[15:12]) && i <= int'(reg_last[15:12])) begin
                    if (reg_first[21:16] == 6'd0) begin
                        lock_hit = lock_hit | cur.locks[i];
                    end else begin
                        lock_hit = lock_hit | cur.locks[int'(flash_prot_pkg::LOCK_TOP) + i];
                    end
                end
            end
        end else begin
            lock_hit = cur.locks[int'(flash_prot_pkg::LOCK_MID) + int'(reg_first[21:16]) - 1];
        end

        area_idx = chk_addr[13:12];
        if (chk_kind == flash_prot_pkg::OP_AREA) begin
            // Area 0 does not exist; a locked area is read-only.
            verdict = (area_idx != 2'd0) && !cur.area_locks[area_idx - 2'd1];  // see RULE2
        end else begin
            verdict = cur.scheme_sel ? !lock_hit : !range_hit;  // see RULE6
        end
    end

    // ====
    // Next state.
    // ====
    // Register writes, commands, check answers and pin decode.
    always_comb begin
        next_ = cur;
        next_.done  = chk_valid;
        next_.allow = chk_valid ? verdict : 1'b0;  // see RULE15

        if (reg_wr) begin
            case (reg_addr)
                flash_prot_pkg::REG_STATUS_ONE: begin
                    next_.sector_gran = reg_wdata[flash_prot_pkg::BIT_SECTOR];
                    next_.top_bottom  = reg_wdata[flash_prot_pkg::BIT_TOPBOT];
                    next_.range_code  = reg_wdata[flash_prot_pkg::BIT_BP_LO +: 3];
                end

                flash_prot_pkg::REG_STATUS_TWO: begin
                    next_.complement  = reg_wdata[flash_prot_pkg::BIT_COMPL];
                    // Locks only ever go to one.
                    next_.area_locks  = cur.area_locks
                                      | reg_wdata[flash_prot_pkg::BIT_LOCK_LO +: 3];  // see RULE1
                    // A four-wire mode already set before the write pins quad enable at one.
                    next_.quad_enable = reg_wdata[flash_prot_pkg::BIT_QUAD]
                                      | cur.four_wire;  // see RULE5
                end

                flash_prot_pkg::REG_STATUS_THREE: begin
                    // Reserved positions are simply not stored.
                    next_.pin_func   = reg_wdata[flash_prot_pkg::BIT_PINF];  // see RULE11
                    next_.drive      = reg_wdata[flash_prot_pkg::BIT_DRV_LO +: 2];
                    next_.scheme_sel = reg_wdata[flash_prot_pkg::BIT_SCHEME];
                end

                flash_prot_pkg::REG_LOCK_SELECT: begin
                    next_.lock_sel = reg_wdata[6:0];
                end

                flash_prot_pkg::REG_LOCK_DATA: begin
                    if (int'(cur.lock_sel) < flash_prot_pkg::NUM_LOCKS) begin
                        next_.locks[cur.lock_sel] = reg_wdata[0];
                    end
                end
                default: begin
                    next_.lock_sel = cur.lock_sel;  // Unmapped writes are dropped.
                end
            endcase
        end

        if (cmd_valid) begin
            if (cmd_code == flash_prot_pkg::CMD_ENTER_4W && cur.quad_enable) begin
                next_.four_wire = 1'b1;  // see RULE4
            end else if (cmd_code == flash_prot_pkg::CMD_EXIT_4W) begin
                next_.four_wire = 1'b0;
            end
        end
        next_.rdata = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                flash_prot_pkg::REG_STATUS_ONE:
                    next_.rdata = {1'b0, cur.sector_gran, cur.top_bottom, cur.range_code, 2'b00};
                flash_prot_pkg::REG_STATUS_TWO:
                    next_.rdata = {1'b0, cur.complement, cur.area_locks, 1'b0,
                                   cur.quad_enable, 1'b0};
                flash_prot_pkg::REG_STATUS_THREE:  // see RULE16
                    next_.rdata = {cur.pin_func, cur.drive, 2'b00, cur.scheme_sel, 2'b00};
                flash_prot_pkg::REG_MODE:
                    next_.rdata = {7'h00, cur.four_wire};
                flash_prot_pkg::REG_LOCK_SELECT:
                    next_.rdata = {1'b0, cur.lock_sel};
                flash_prot_pkg::REG_LOCK_DATA:
                    next_.rdata = {7'h00, (int'(cur.lock_sel) < flash_prot_pkg::NUM_LOCKS)
                                   ? cur.locks[cur.lock_sel] : 1'b0};
                default:
                    next_.rdata = 8'h00;  // Unmapped reads return zero.
            endcase
        end
        // The first stage is read only by the second.
        next_.pin_meta = shared_pin_n;
        next_.pin_sync = cur.pin_meta;
        // Quad enable hands both pins over to data.
        next_.quad_io = cur.quad_enable;  // see RULE3
        next_.wp_on   = !cur.quad_enable;  // see RULE3
        next_.hold = !cur.quad_enable && !cur.pin_func && !cur.pin_sync;  // see RULE9 RULE10
        next_.prst = !cur.quad_enable && cur.pin_func && !cur.pin_sync;   // see RULE9 RULE10
    end

    // ====
    // State register.
    // ====
    // Reset sets every individual lock, so the array is protected once the individual lock scheme is selected.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cur          <= '0;
            cur.locks    <= '1;  // see RULE7
            cur.drive    <= flash_prot_pkg::DRV_RESET;  // see RULE8
            cur.pin_meta <= 1'b1;
            cur.pin_sync <= 1'b1;
            cur.wp_on    <= 1'b1;
        end else begin
            cur <= next_;
        end
    end

    // ====
    // Outputs.
    // ====

    assign reg_rdata       = cur.rdata;
    assign chk_done        = cur.done;
    assign chk_allow       = cur.allow;
    assign four_wire_mode  = cur.four_wire;
    assign quad_data_lines = cur.quad_io;
    assign wp_function_on  = cur.wp_on;
    assign hold_active     = cur.hold;
    assign pin_reset_req   = cur.prst;
    assign drive_strength  = cur.drive;  // see RULE8

    // ====
    // Assertions.
    // ====

    lock_sticky_a: assert property (@(posedge ref_clk) disable iff (!resetn)  // see RULE1
        ((cur.area_locks & $past(cur.area_locks)) == $past(cur.area_locks)))
        else $error("Security lock bit fell back to zero.");

    area_locked_a: assert property (@(posedge ref_clk) disable iff (!resetn)  // see RULE2
        (chk_valid && chk_kind == flash_prot_pkg::OP_AREA && chk_addr[13:12] != 2'd0
         && cur.area_locks[chk_addr[13:12] - 2'd1]) |=> (chk_done && !chk_allow))
        else $error("Locked security area was allowed.");

    quad_pins_a: assert property (@(posedge ref_clk) disable iff (!resetn)  // see RULE10
        $rose(cur.quad_enable) |=> (quad_data_lines && !wp_function_on
                                    && !hold_active && !pin_reset_req))
        else $error("Pin functions live with quad enable set.");

    enter_gate_a: assert property (@(posedge ref_clk) disable iff (!resetn)  // see RULE4
        (cmd_valid && cmd_code == flash_prot_pkg::CMD_ENTER_4W && !cur.quad_enable
         && !cur.four_wire) |=> !four_wire_mode)
        else $error("Four-wire mode entered without quad enable.");

    qe_held_a: assert property (@(posedge ref_clk) disable iff (!resetn)  // see RULE5
        cur.four_wire |-> cur.quad_enable)
        else $error("Quad enable cleared in four-wire mode.");

    drive_follow_a: assert property (@(posedge ref_clk) disable iff (!resetn)  // see RULE8
        (reg_wr && reg_addr == flash_prot_pkg::REG_STATUS_THREE)
        |=> (drive_strength == $past(reg_wdata[flash_prot_pkg::BIT_DRV_LO +: 2])))
        else $error("Drive field did not take the written code.");

    code_none_a: assert property (@(posedge ref_clk) disable iff (!resetn)  // see RULE12
        (chk_valid && chk_kind != flash_prot_pkg::OP_AREA && !cur.scheme_sel
         && !cur.complement && cur.range_code == 3'b000) |=> (chk_done && chk_allow))
        else $error("Code 000 refused an operation.");

    code_all_a: assert property (@(posedge ref_clk) disable iff (!resetn)  // see RULE12
        (chk_valid && chk_kind != flash_prot_pkg::OP_AREA && !cur.scheme_sel
         && cur.range_code == 3'b111) |=> (chk_done && !chk_allow))
        else $error("Code 111 allowed an operation.");

    hold_pin_a: assert property (@(posedge ref_clk) disable iff (!resetn)  // see RULE9
        (!cur.quad_enable && !cur.pin_func && !cur.pin_sync) |=> hold_active)
        else $error("Hold not asserted from the shared pin.");

    done_pulse_a: assert property (@(posedge ref_clk) disable iff (!resetn)  // see RULE15
        chk_valid |=> chk_done)
        else $error("Check request got no answer.");

    wp_follow_a: assert property (@(posedge ref_clk) disable iff (!resetn)  // see RULE3
        !cur.quad_enable |=> wp_function_on)
        else $error("Write-protect function off with quad enable clear.");

    scheme_lock_a: assert property (@(posedge ref_clk) disable iff (!resetn)  // see RULE6
        (chk_valid && chk_kind != flash_prot_pkg::OP_AREA && cur.scheme_sel && lock_hit)
        |=> !chk_allow)
        else $error("Locked sector allowed under lock scheme.");

endmodule

/* File: sim/spi_host_model.sv */
`timescale 1ns/10ps
// ====
// Host side: issues mode commands and program or erase checks.
// ====
module spi_host_model (
    input  wire logic                 ref_clk,   // Shared clock.
    output logic                      cmd_valid, // Command strobe.
    output logic [7:0]                cmd_code,  // Command byte.
    output logic                      chk_valid, // Check strobe.
    output flash_prot_pkg::op_kind_t  chk_kind,  // Operation kind.
    output logic [21:0]               chk_addr,  // Target address.
    input  wire logic                 chk_done,  // Answer pulse.
    input  wire logic                 chk_allow  // Verdict.
);
    // Idle strobes low from time zero so nothing is taken during reset.
    initial begin
        cmd_valid = 1'b0;
        cmd_code  = 8'h00;
        chk_valid = 1'b0;
        chk_kind  = flash_prot_pkg::OP_PAGE;
        chk_addr  = 22'h000000;
    end
    // One-cycle command; the bench sets quad enable first except on purpose.
    task automatic send_cmd(input logic [7:0] code);
        @(posedge ref_clk);
        cmd_valid <= 1'b1;
        cmd_code  <= code;
        @(posedge ref_clk);
        cmd_valid <= 1'b0;
    endtask
    // The answer stands one cycle only, so it is sampled just after that edge.
    task automatic check(input flash_prot_pkg::op_kind_t k, input logic [21:0] a,
                         output logic done, output logic allow);
        @(posedge ref_clk);
        chk_valid <= 1'b1;
        chk_kind  <= k;
        chk_addr  <= a;
        @(posedge ref_clk);
        chk_valid <= 1'b0;
        #1;
        done  = chk_done;
        allow = chk_allow;
    endtask
endmodule

/* File: sim/testbench.sv */
`timescale 1ns/10ps
// ====
// Self-checking bench for the status and protection block.
// ====
module testbench;
    logic                     ref_clk, resetn, reg_wr, reg_rd, shared_pin_n; // Inputs.
    logic [7:0]               reg_addr, reg_wdata, reg_rdata, cmd_code;      // Bus bytes.
    logic                     cmd_valid, chk_valid, chk_done, chk_allow;     // Strobes.
    flash_prot_pkg::op_kind_t chk_kind;                                      // Kind.
    logic [21:0]              chk_addr, sz;                                  // Addresses.
    logic [4:0]               pin_out;                                       // Pin outputs.
    logic [1:0]               drive_strength;                                // Drive code.
    int                       fails, cmp_count;                              // Counters.
    localparam logic [7:0] R1 = flash_prot_pkg::REG_STATUS_ONE;   // Status byte one.
    localparam logic [7:0] R2 = flash_prot_pkg::REG_STATUS_TWO;   // Status byte two.
    localparam logic [7:0] R3 = flash_prot_pkg::REG_STATUS_THREE; // Status byte three.
    flash_status_config_protect u_flash_status_config_protect (.ref_clk(ref_clk),
        .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .chk_valid(chk_valid), .chk_kind(chk_kind), .chk_addr(chk_addr),
        .chk_done(chk_done), .chk_allow(chk_allow), .shared_pin_n(shared_pin_n),
        .four_wire_mode(pin_out[4]), .quad_data_lines(pin_out[3]),
        .wp_function_on(pin_out[2]), .hold_active(pin_out[1]),
        .pin_reset_req(pin_out[0]), .drive_strength(drive_strength));
    spi_host_model u_spi_host_model (.ref_clk(ref_clk), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .chk_valid(chk_valid), .chk_kind(chk_kind),
        .chk_addr(chk_addr), .chk_done(chk_done), .chk_allow(chk_allow));
    // ====
    // Shared tasks.
    // ====
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    // Read data stand only in the cycle after the strobe.
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 check(reg_rdata, exp);
    endtask
    task automatic op_chk(input flash_prot_pkg::op_kind_t k, input logic [21:0] a,
                          input logic e);
        logic d, al;
        u_spi_host_model.check(k, a, d, al);
        check({6'h00, d, al}, {6'h00, 1'b1, e});
    endtask
    // Pin outputs settle within three edges of a change; four are allowed.
    task automatic pins(input logic [4:0] e);
        repeat (4) @(posedge ref_clk);
        #1 check({3'b000, pin_out}, {3'b000, e});
    endtask
    // ====
    // Scenarios.
    // ====
    task automatic t_reset();
        rd_chk(R3, 8'h60);
        wr(flash_prot_pkg::REG_LOCK_SELECT, 8'h5d);
        rd_chk(flash_prot_pkg::REG_LOCK_DATA, 8'h01);
        pins(5'b00100);
        $display("reset test done");
    endtask
    task automatic t_drive();
        for (int i = 0; i < 4; i++) begin
            wr(R3, {1'b0, i[1:0], 5'h00});
            check({6'h00, drive_strength}, {6'h00, i[1:0]});
        end
        wr(R3, 8'hff);
        rd_chk(R3, 8'he4);
        wr(R3, 8'h60);
        $display("drive test done");
    endtask
    task automatic t_locks();
        wr(R2, 8'h08);
        wr(R2, 8'h00);
        rd_chk(R2, 8'h08);
        wr(R2, 8'h20);
        rd_chk(R2, 8'h28);
        op_chk(flash_prot_pkg::OP_AREA, 22'h001000, 1'b0);
        op_chk(flash_prot_pkg::OP_AREA, 22'h002000, 1'b1);
        $display("lock test done");
    endtask
    // Host sends 38h only after quad enable, except once here to see it ignored.
    task automatic t_quad();
        shared_pin_n <= 1'b0;
        u_spi_host_model.send_cmd(flash_prot_pkg::CMD_ENTER_4W);
        pins(5'b00110);
        wr(R3, 8'he0);
        pins(5'b00101);
        wr(R2, 8'h02);
        pins(5'b01000);
        u_spi_host_model.send_cmd(flash_prot_pkg::CMD_ENTER_4W);
        pins(5'b11000);
        wr(R2, 8'h00);
        rd_chk(R2, 8'h2a);
        u_spi_host_model.send_cmd(flash_prot_pkg::CMD_EXIT_4W);
        wr(R2, 8'h00);
        pins(5'b00101);
        shared_pin_n <= 1'b1;
        wr(R3, 8'h60);
        $display("quad test done");
    endtask
    task automatic t_range();
        for (int c = 1; c < 7; c++) begin
            sz = flash_prot_pkg::SIZE_64K << (c - 1);
            wr(R1, {3'b000, c[2:0], 2'b00});
            op_chk(flash_prot_pkg::OP_BLOCK, 22'h3fffff - sz + 22'h1, 1'b0);
            op_chk(flash_prot_pkg::OP_BLOCK, 22'h3effff - sz + 22'h1, 1'b1);
            wr(R1, {3'b001, c[2:0], 2'b00});
            op_chk(flash_prot_pkg::OP_BLOCK, sz - 22'h010000, 1'b0);
            op_chk(flash_prot_pkg::OP_BLOCK, sz, 1'b1);
        end
        for (int c = 1; c < 6; c++) begin
            sz = flash_prot_pkg::SIZE_4K << ((c > 4 ? 4 : c) - 1);
            wr(R1, {3'b010, c[2:0], 2'b00});
            op_chk(flash_prot_pkg::OP_SECTOR, 22'h3fffff - sz + 22'h1, 1'b0);
            op_chk(flash_prot_pkg::OP_SECTOR, 22'h3fefff - sz + 22'h1, 1'b1);
            wr(R1, {3'b011, c[2:0], 2'b00});
            op_chk(flash_prot_pkg::OP_SECTOR, sz - 22'h001000, 1'b0);
            op_chk(flash_prot_pkg::OP_SECTOR, sz, 1'b1);
        end
        wr(R1, 8'h60);
        op_chk(flash_prot_pkg::OP_CHIP, 22'h000000, 1'b1);
        wr(R1, 8'h7c);
        op_chk(flash_prot_pkg::OP_PAGE, 22'h1fff00, 1'b0);
        wr(R1, 8'h04);
        op_chk(flash_prot_pkg::OP_CHIP, 22'h000000, 1'b0);
        $display("range test done");
    endtask
    task automatic t_scheme();
        wr(R1, 8'h1c);
        wr(R3, 8'h64);
        wr(flash_prot_pkg::REG_LOCK_SELECT, 8'h00);
        wr(flash_prot_pkg::REG_LOCK_DATA, 8'h00);
        op_chk(flash_prot_pkg::OP_PAGE, 22'h000000, 1'b1);
        op_chk(flash_prot_pkg::OP_PAGE, 22'h001000, 1'b0);
        wr(R3, 8'h60);
        op_chk(flash_prot_pkg::OP_PAGE, 22'h000000, 1'b0);
        $display("scheme test done");
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // ====
    // Clock, watchdog and main sequence.
    // ====
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    // The tests need under 2,000 cycles; 20,000 leaves ample margin.
    initial begin
        #2000000;
        fails++;
        $display("ERROR %0t: watchdog expired", $time);
        end_of_test();
    end
    initial begin
        {resetn, reg_wr, reg_rd, reg_addr, reg_wdata, fails, cmp_count} = '0;
        shared_pin_n = 1'b1;
        repeat (16) @(posedge ref_clk);
        resetn <= 1'b1;
        t_reset();
        t_drive();
        t_locks();
        t_quad();
        t_range();
        t_scheme();
        end_of_test();
    end
endmodule
